// [shared/pmpfgr_defines.svh]
`ifndef PMPFGR_DEFINES_SVH
`define PMPFGR_DEFINES_SVH

// ==========================================================
// configuration space offsets
`define PMPFGR_OFS_POLICY_STATUS 8'ha4
`define PMPFGR_OFS_GPI_ROUTING 8'hb8

// ==========================================================
// power fail policy and status field positions
`define PMPFGR_BIT_CLK_LOST 2
`define PMPFGR_BIT_TRICKLE_FAIL 1
`define PMPFGR_BIT_RESTORE_POLICY 0

// ==========================================================
// reset values
`define PMPFGR_RST_POLICY_STATUS 8'h00
`define PMPFGR_RST_GPI_ROUTING 32'h0000_0000
`define PMPFGR_RST_CLK_LOST 1'b1
`define PMPFGR_RST_TRICKLE_FAIL 1'b0
`define PMPFGR_RST_RESTORE_POLICY 1'b0

// ==========================================================
// routing field layout
`define PMPFGR_ROUTE_FIELD_W 2
`define PMPFGR_ROUTE_IMPL_MASK 32'h0fcf_fc0f

`endif

// [shared/pmpfgr_pkg.sv]
package pmpfgr_pkg;

  // ==========================================================
  // routing field encoding
  typedef enum logic [1:0]
  {
    ROUTE_NONE = 2'h0,
    ROUTE_MGMT = 2'h1,
    ROUTE_ACPI = 2'h2,
    ROUTE_RSVD = 2'h3
  } pmpfgr_route_type;

  // ==========================================================
  // state chosen when power comes back
  typedef enum logic [1:0]
  {
    PWR_S0 = 2'h0,
    PWR_S4 = 2'h1,
    PWR_S5 = 2'h2
  } pmpfgr_pwr_state_type;

  // ==========================================================
  // power restore tracking, one-hot
  typedef enum logic [2:0]
  {
    PR_RUN = 3'h1,
    PR_SOFT_OFF = 3'h2,
    PR_HIBERNATE = 3'h4
  } pmpfgr_restore_fsm_type;

endpackage

// [rtl/pmpfgr_sync.sv]
module pmpfgr_sync #(
  parameter int WIDTH = 1,
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // ==========================================================
  // two flops, first one feeds only the second
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      stage1_reg <= {WIDTH{RESET_VAL}};
      stage2_reg <= {WIDTH{RESET_VAL}};
    end
    else
    begin
      stage1_reg <= d_i;
      stage2_reg <= stage1_reg;
    end
  end

  assign q_o = stage2_reg;
endmodule

// [rtl/pmpfgr_route_lane.sv]
module pmpfgr_route_lane #(
  parameter bit IMPLEMENTED = 1'b1
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire pmpfgr_pkg::pmpfgr_route_type route_i,
  input wire logic flag_i,
  input wire logic enable_i,
  input wire logic is_input_i,
  input wire logic sleeping_i,
  output logic mgmt_req_o,
  output logic acpi_req_o,
  output logic wake_req_o
);
  import pmpfgr_pkg::*;

  logic flag_prev_reg;
  logic flag_rise;
  logic live;

  // ==========================================================
  // remember the flag to see it become set
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      flag_prev_reg <= 1'b0;
    else
      flag_prev_reg <= flag_i;
  end

  // event only for implemented inputs configured as input
  // flag becomes set
  assign flag_rise = flag_i && !flag_prev_reg;
  assign live = IMPLEMENTED && is_input_i && flag_rise && enable_i;
  assign mgmt_req_o = live && (route_i == ROUTE_MGMT);
  assign acpi_req_o = live && (route_i == ROUTE_ACPI);
  assign wake_req_o = live && sleeping_i;
endmodule

// [rtl/pmpfgr_top.sv]
`include "pmpfgr_defines.svh"

module pmpfgr_top #(
  parameter int GPI_COUNT = 16
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic battery_well_reset_n_i,
  input wire logic trickle_fail_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_ack_o,
  input wire logic reset_port_write_i,
  input wire logic power_restored_i,
  input wire logic was_in_s4_i,
  input wire logic power_button_event_i,
  input wire logic preserved_wake_event_i,
  input wire logic other_wake_event_i,
  input wire logic [GPI_COUNT-1:0] gp_input_event_flag_i,
  input wire logic [GPI_COUNT-1:0] group1_event_enable_i,
  input wire logic [GPI_COUNT-1:0] gpio_is_input_i,
  input wire logic sleeping_i,
  output logic mgmt_interrupt_n_o,
  output logic acpi_ctrl_int_o,
  output logic wake_request_o,
  output logic resume_well_reset_n_o,
  output pmpfgr_pkg::pmpfgr_pwr_state_type restore_target_o,
  output logic restore_done_o
);
  import pmpfgr_pkg::*;

  // ==========================================================
  // elaboration check
  generate
    if (GPI_COUNT != 16)
    begin : g_bad_count
      $error("routing register serves exactly sixteen inputs");
    end
  endgenerate

  // ==========================================================
  // helpers
  function automatic pmpfgr_route_type route_field(input logic [31:0] word, input int n);
    route_field = pmpfgr_route_type'(word[2*n +: `PMPFGR_ROUTE_FIELD_W]);
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // ==========================================================
  // declarations
  logic bw_rst_n;
  logic trickle_sync;
  logic clk_lost_reg;
  logic clk_lost_next;
  logic trickle_reg;
  logic trickle_next;
  logic policy_reg;
  logic policy_next;
  logic [31:0] route_reg;
  logic [31:0] route_next;
  logic [31:0] rdata_next;
  logic [31:0] wmask;
  logic status_hit;
  logic route_hit;
  logic status_wr;
  logic route_wr;
  logic [GPI_COUNT-1:0] lane_mgmt;
  logic [GPI_COUNT-1:0] lane_acpi;
  logic [GPI_COUNT-1:0] lane_wake;
  pmpfgr_restore_fsm_type state_reg;
  pmpfgr_restore_fsm_type state_next;
  pmpfgr_pwr_state_type target_next;
  logic wake_any;
  logic wake_accepted;

  // ==========================================================
  // battery well reset: async assert, synchronous release
  pmpfgr_sync #(
    .WIDTH(1),
    .RESET_VAL(1'b0)
  ) u_bw_rst_sync (
    .clock_i(clock_i),
    .arst_n_i(battery_well_reset_n_i),
    .d_i(1'b1),
    .q_o(bw_rst_n)
  );

  // trickle failure pin into the clock domain
  pmpfgr_sync #(
    .WIDTH(1),
    .RESET_VAL(1'b0)
  ) u_trickle_sync (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .d_i(trickle_fail_i),
    .q_o(trickle_sync)
  );

  // ==========================================================
  // config access decode
  assign status_hit = (cfg_addr_i[7:2] == 6'(`PMPFGR_OFS_POLICY_STATUS >> 2));
  assign route_hit = (cfg_addr_i[7:2] == 6'(`PMPFGR_OFS_GPI_ROUTING >> 2));
  assign status_wr = cfg_wr_i && status_hit && cfg_be_i[0];
  assign route_wr = cfg_wr_i && route_hit;
  assign wmask = lane_mask(cfg_be_i);

  // ==========================================================
  // battery well status next values
  // write zero clears, else hold
  assign clk_lost_next = (status_wr && !cfg_wdata_i[`PMPFGR_BIT_CLK_LOST]) ? 1'b0 : clk_lost_reg;
  // failure sets, set beats the clear
  assign trickle_next = trickle_sync ? 1'b1 :
                        (status_wr && cfg_wdata_i[`PMPFGR_BIT_TRICKLE_FAIL]) ? 1'b0 : trickle_reg;
  // reset port write clears the policy
  assign policy_next = reset_port_write_i ? 1'b0 :
                       status_wr ? cfg_wdata_i[`PMPFGR_BIT_RESTORE_POLICY] : policy_reg;

  // ==========================================================
  // battery well flops, only the battery reset touches them
  // reset low forces lost flag set
  always_ff @(posedge clock_i or negedge bw_rst_n)
  begin
    if (!bw_rst_n)
    begin
      clk_lost_reg <= `PMPFGR_RST_CLK_LOST;
      trickle_reg <= `PMPFGR_RST_TRICKLE_FAIL;
      policy_reg <= `PMPFGR_RST_RESTORE_POLICY;
    end
    else
    begin
      clk_lost_reg <= clk_lost_next;
      trickle_reg <= trickle_next;
      policy_reg <= policy_next;
    end
  end

  // ==========================================================
  // routing register in the resume well
  // unimplemented fields never store
  assign route_next = route_wr ?
                      ((route_reg & ~wmask) | (cfg_wdata_i & wmask)) & `PMPFGR_ROUTE_IMPL_MASK :
                      route_reg;

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      route_reg <= `PMPFGR_RST_GPI_ROUTING;
    else
      route_reg <= route_next;
  end

  // ==========================================================
  // read data, unmapped reads return zero
  // reserved bits read zero
  assign rdata_next = status_hit ? {29'h0000_0000, clk_lost_reg, trickle_reg, policy_reg} :
                      route_hit ? route_reg : 32'h0000_0000;

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cfg_rdata_o <= 32'h0000_0000;
      cfg_ack_o <= 1'b0;
    end
    else
    begin
      cfg_rdata_o <= cfg_rd_i ? rdata_next : cfg_rdata_o;
      cfg_ack_o <= cfg_rd_i || cfg_wr_i;
    end
  end

  // ==========================================================
  // one lane per input
  // field n at bits 2n+1:2n
  genvar gi;
  generate
    for (gi = 0; gi < GPI_COUNT; gi++)
    begin : g_lane
      pmpfgr_route_lane #(
        .IMPLEMENTED(1'((`PMPFGR_ROUTE_IMPL_MASK >> (2 * gi)) & 32'h1))
      ) u_lane (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .route_i(route_field(route_reg, gi)),
        .flag_i(gp_input_event_flag_i[gi]),
        .enable_i(group1_event_enable_i[gi]),
        .is_input_i(gpio_is_input_i[gi]),
        .sleeping_i(sleeping_i),
        .mgmt_req_o(lane_mgmt[gi]),
        .acpi_req_o(lane_acpi[gi]),
        .wake_req_o(lane_wake[gi])
      );
    end
  endgenerate

  // ==========================================================
  // power restore tracking
  // restored soft-off narrows wake sources
  assign wake_any = power_button_event_i || preserved_wake_event_i;
  assign wake_accepted = (state_reg == PR_SOFT_OFF) ? wake_any :
                         (wake_any || other_wake_event_i || (|lane_wake));

  always_comb
  begin
    state_next = state_reg;
    target_next = restore_target_o;
    case (state_reg)
      PR_RUN, PR_SOFT_OFF, PR_HIBERNATE:
      begin
        if (power_restored_i)
        begin
          if (!policy_reg)
          begin
            state_next = PR_RUN;
            target_next = PWR_S0;
          end
          // policy one: S4 stays S4, else soft-off
          else if (was_in_s4_i)
          begin
            state_next = PR_HIBERNATE;
            target_next = PWR_S4;
          end
          else
          begin
            state_next = PR_SOFT_OFF;
            target_next = PWR_S5;
          end
        end
        else if (wake_accepted && (state_reg != PR_RUN))
        begin
          state_next = PR_RUN;
          target_next = PWR_S0;
        end
      end
      default:
      begin
        state_next = PR_RUN;
        target_next = PWR_S0;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_reg <= PR_RUN;
      restore_target_o <= PWR_S0;
      restore_done_o <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      restore_target_o <= target_next;
      restore_done_o <= power_restored_i;
    end
  end

  // ==========================================================
  // interrupt, wake and resume reset outputs
  // management active low, acpi active high
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mgmt_interrupt_n_o <= 1'b1;
      acpi_ctrl_int_o <= 1'b0;
      wake_request_o <= 1'b0;
      resume_well_reset_n_o <= 1'b0;
    end
    else
    begin
      mgmt_interrupt_n_o <= ~(|lane_mgmt);
      acpi_ctrl_int_o <= |lane_acpi;
      wake_request_o <= wake_accepted && !power_restored_i;
      resume_well_reset_n_o <= ~trickle_sync;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clock_i);
  endclocking

  a_clk_lost_release: assert property (disable iff (!arst_n_i) $rose(bw_rst_n) |-> clk_lost_reg)
    else $error("lost flag not set after battery reset");

  a_clk_lost_clear: assert property (disable iff (!bw_rst_n)
    status_wr && !cfg_wdata_i[`PMPFGR_BIT_CLK_LOST] |=> !clk_lost_reg)
    else $error("lost flag not cleared by zero write");

  a_clk_lost_hold: assert property (disable iff (!bw_rst_n)
    clk_lost_reg && !status_wr |=> clk_lost_reg)
    else $error("lost flag dropped without write");

  a_trickle_set: assert property (disable iff (!bw_rst_n) trickle_sync |=> trickle_reg)
    else $error("trickle flag not set on failure");

  a_resume_reset_drive: assert property (disable iff (!arst_n_i)
    trickle_sync |=> !resume_well_reset_n_o)
    else $error("resume reset not driven on trickle failure");

  a_trickle_clear: assert property (disable iff (!bw_rst_n || !arst_n_i)
    status_wr && cfg_wdata_i[`PMPFGR_BIT_TRICKLE_FAIL] && !trickle_sync ##1 !trickle_sync |-> !trickle_reg)
    else $error("trickle flag not cleared by one write");

  a_trickle_survive: assert property (disable iff (!bw_rst_n)
    trickle_reg && !(status_wr && cfg_wdata_i[`PMPFGR_BIT_TRICKLE_FAIL]) |=> trickle_reg)
    else $error("trickle flag lost without battery reset");

  a_boot_policy: assert property (disable iff (!arst_n_i || !bw_rst_n)
    power_restored_i && !policy_reg |=> restore_target_o == PWR_S0 && restore_done_o && state_reg == PR_RUN)
    else $error("policy zero did not boot");

  a_soft_off_policy: assert property (disable iff (!arst_n_i || !bw_rst_n)
    power_restored_i && policy_reg |=> restore_target_o == ($past(was_in_s4_i) ? PWR_S4 : PWR_S5))
    else $error("policy one chose wrong state");

  a_soft_off_wake: assert property (disable iff (!arst_n_i)
    state_reg == PR_SOFT_OFF && !wake_any && !power_restored_i |=> !wake_request_o && state_reg == PR_SOFT_OFF)
    else $error("soft-off woke on unpreserved source");

  a_policy_clear: assert property (disable iff (!bw_rst_n) reset_port_write_i |=> !policy_reg)
    else $error("reset port write left policy set");

  a_route_mgmt: assert property (disable iff (!arst_n_i)
    $rose(gp_input_event_flag_i[0]) && route_reg[1:0] == ROUTE_MGMT && group1_event_enable_i[0]
    && gpio_is_input_i[0] |=> !mgmt_interrupt_n_o)
    else $error("routed management interrupt missing");

  a_route_non_input: assert property (disable iff (!arst_n_i)
    (gpio_is_input_i | ~group1_event_enable_i) == 16'h0000 |=> mgmt_interrupt_n_o && !acpi_ctrl_int_o)
    else $error("interrupt from a non-input pin");

  a_gpi_wake: assert property (disable iff (!arst_n_i)
    sleeping_i && $rose(gp_input_event_flag_i[0]) && group1_event_enable_i[0] && gpio_is_input_i[0]
    && state_reg != PR_SOFT_OFF && !power_restored_i |=> wake_request_o)
    else $error("enabled input failed to wake");

  a_route_reserved: assert property (disable iff (!arst_n_i)
    cfg_rd_i && route_hit |=> (cfg_rdata_o & ~`PMPFGR_ROUTE_IMPL_MASK) == 32'h0000_0000)
    else $error("unimplemented routing bits read nonzero");

  a_route_readback: assert property (disable iff (!arst_n_i)
    cfg_rd_i && route_hit && !cfg_wr_i |=> cfg_rdata_o == $past(route_reg))
    else $error("routing read does not match stored fields");

  a_status_reserved: assert property (disable iff (!arst_n_i)
    cfg_rd_i && status_hit |=> cfg_rdata_o[31:3] == 29'h0000_0000)
    else $error("reserved status bits read nonzero");

  c_soft_off: cover property (disable iff (!arst_n_i) state_reg == PR_SOFT_OFF ##1 state_reg == PR_RUN);
  c_mgmt_int: cover property (disable iff (!arst_n_i) !mgmt_interrupt_n_o);
  c_acpi_int: cover property (disable iff (!arst_n_i) acpi_ctrl_int_o);
  c_gpi_wake: cover property (disable iff (!arst_n_i) |lane_wake ##1 wake_request_o);
endmodule

// [dv/pmpfgr_tb_top.sv]
`include "pmpfgr_defines.svh"

module pmpfgr_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pmpfgr_pkg::*;

  // ==========================================================
  // signals
  logic clock_i = 1'b0;
  logic arst_n_i, battery_well_reset_n_i, trickle_fail_i;
  logic [7:0] cfg_addr_i;
  logic [3:0] cfg_be_i;
  logic cfg_wr_i, cfg_rd_i;
  logic [31:0] cfg_wdata_i, cfg_rdata_o;
  logic cfg_ack_o, reset_port_write_i, power_restored_i, was_in_s4_i;
  logic power_button_event_i, preserved_wake_event_i, other_wake_event_i, sleeping_i;
  logic [15:0] gp_input_event_flag_i, group1_event_enable_i, gpio_is_input_i;
  logic mgmt_interrupt_n_o, acpi_ctrl_int_o, wake_request_o, resume_well_reset_n_o, restore_done_o;
  pmpfgr_pwr_state_type restore_target_o;
  int miscompares = 0;
  int check_count = 0;
  int cycle_count = 0;
  // implemented inputs 0,1,5-9,11-13
  localparam logic [15:0] IMPL = 16'h3be3;

  pmpfgr_top #(.GPI_COUNT(16)) dut (.*);

  // ==========================================================
  // clock and timeout
  always #20 clock_i = ~clock_i;

  always @(posedge clock_i)
  begin
    cycle_count++;
    if (cycle_count == 20000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  // ==========================================================
  // compare and report
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================
  // bus and event helpers
  task automatic cfg_xfer(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                          input logic [31:0] wd, output logic [31:0] rd);
    int k;
    @(posedge clock_i);
    #1;
    cfg_addr_i = addr;
    cfg_be_i = be;
    cfg_wdata_i = wd;
    cfg_wr_i = wr;
    cfg_rd_i = !wr;
    @(posedge clock_i);
    #1;
    cfg_wr_i = 1'b0;
    cfg_rd_i = 1'b0;
    k = 0;
    while (cfg_ack_o !== 1'b1 && k < 4)
    begin
      @(posedge clock_i);
      #1;
      k++;
    end
    chk_word({31'h0, cfg_ack_o}, 32'h1, "ack");
    rd = cfg_rdata_o;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [3:0] be, input logic [31:0] wd);
    logic [31:0] d;
    cfg_xfer(1'b1, addr, be, wd, d);
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] d;
    cfg_xfer(1'b0, addr, 4'hf, 32'h0, d);
    chk_word(d, exp, "read data");
  endtask

  // watch three edges; result is {mgmt, acpi, wake, done}, pulse inputs dropped after one cycle
  task automatic watch(output logic [3:0] s);
    s = 4'h0;
    repeat (3)
    begin
      @(posedge clock_i);
      #1;
      {power_restored_i, reset_port_write_i, power_button_event_i} = 3'h0;
      {preserved_wake_event_i, other_wake_event_i} = 2'h0;
      s = s | {mgmt_interrupt_n_o === 1'b0, acpi_ctrl_int_o === 1'b1, wake_request_o === 1'b1,
               restore_done_o === 1'b1};
    end
  endtask

  task automatic gpi_event(input int n, input logic [3:0] exp);
    logic [3:0] s;
    @(posedge clock_i);
    #1;
    gp_input_event_flag_i = 16'h1 << n;
    watch(s);
    gp_input_event_flag_i = 16'h0;
    chk_word({28'h0, s}, {28'h0, exp}, "gpi outputs");
  endtask

  task automatic do_restore(input logic s4, input pmpfgr_pwr_state_type tgt);
    logic [3:0] s;
    @(posedge clock_i);
    #1;
    power_restored_i = 1'b1;
    was_in_s4_i = s4;
    watch(s);
    chk_word({28'h0, s}, 32'h1, "restore pulse");
    chk_word({30'h0, restore_target_o}, {30'h0, tgt}, "restore target");
  endtask

  task automatic do_wake(input int src, input logic [3:0] exp);
    logic [3:0] s;
    @(posedge clock_i);
    #1;
    other_wake_event_i = (src == 0);
    power_button_event_i = (src == 1);
    preserved_wake_event_i = (src == 2);
    watch(s);
    chk_word({28'h0, s}, {28'h0, exp}, "wake");
  endtask

  // ==========================================================
  // scenarios
  // status bits: lost flag clear by zero, reserved bits, lane gating, reset port
  task automatic test_status();
    rd_chk(`PMPFGR_OFS_POLICY_STATUS, 32'h4);
    rd_chk(`PMPFGR_OFS_GPI_ROUTING, 32'h0);
    wr(`PMPFGR_OFS_POLICY_STATUS, 4'h1, 32'h0);
    rd_chk(`PMPFGR_OFS_POLICY_STATUS, 32'h0);
    wr(`PMPFGR_OFS_POLICY_STATUS, 4'h1, 32'hffff_fffd);
    rd_chk(`PMPFGR_OFS_POLICY_STATUS, 32'h1);
    @(posedge clock_i);
    #1;
    reset_port_write_i = 1'b1;
    @(posedge clock_i);
    #1;
    reset_port_write_i = 1'b0;
    rd_chk(`PMPFGR_OFS_POLICY_STATUS, 32'h0);
    wr(`PMPFGR_OFS_POLICY_STATUS, 4'h0, 32'h1);
    rd_chk(`PMPFGR_OFS_POLICY_STATUS, 32'h0);
  endtask

  // trickle failure: flag set, resume reset, survives main reset, write one clears
  task automatic test_trickle();
    @(posedge clock_i);
    #1;
    trickle_fail_i = 1'b1;
    repeat (4) @(posedge clock_i);
    #1;
    chk_word({31'h0, resume_well_reset_n_o}, 32'h0, "resume reset");
    trickle_fail_i = 1'b0;
    repeat (4) @(posedge clock_i);
    #1;
    chk_word({31'h0, resume_well_reset_n_o}, 32'h1, "resume release");
    rd_chk(`PMPFGR_OFS_POLICY_STATUS, 32'h2);
    arst_n_i = 1'b0;
    @(posedge clock_i);
    #1;
    arst_n_i = 1'b1;
    repeat (3) @(posedge clock_i);
    rd_chk(`PMPFGR_OFS_POLICY_STATUS, 32'h2);
    wr(`PMPFGR_OFS_POLICY_STATUS, 4'h1, 32'h2);
    rd_chk(`PMPFGR_OFS_POLICY_STATUS, 32'h0);
  endtask

  // routing register: implemented mask, byte lanes, unmapped address
  task automatic test_route_regs();
    wr(`PMPFGR_OFS_GPI_ROUTING, 4'hf, 32'hffff_ffff);
    rd_chk(`PMPFGR_OFS_GPI_ROUTING, 32'h0fcf_fc0f);
    wr(`PMPFGR_OFS_GPI_ROUTING, 4'h2, 32'h0);
    rd_chk(`PMPFGR_OFS_GPI_ROUTING, 32'h0fcf_000f);
    wr(8'h40, 4'hf, 32'hffff_ffff);
    rd_chk(8'h40, 32'h0);
    rd_chk(`PMPFGR_OFS_GPI_ROUTING, 32'h0fcf_000f);
  endtask

  // every code in every field position, then enable and direction gating
  task automatic test_route_decode();
    logic [3:0] exp;
    for (int n = 0; n < 16; n++)
    begin
      for (int c = 0; c < 4; c++)
      begin
        wr(`PMPFGR_OFS_GPI_ROUTING, 4'hf, 32'(c) << (2 * n));
        exp = {IMPL[n] && c == 1, IMPL[n] && c == 2, 2'b00};
        gpi_event(n, exp);
      end
    end
    wr(`PMPFGR_OFS_GPI_ROUTING, 4'hf, 32'h0100_0001);
    group1_event_enable_i = 16'hfffe;
    gpi_event(0, 4'b0000);
    gpi_event(12, 4'b1000);
    group1_event_enable_i = 16'hffff;
    gpio_is_input_i = 16'h0000;
    gpi_event(0, 4'b0000);
    gpi_event(12, 4'b0000);
    gpio_is_input_i = 16'hffff;
  endtask

  // wake from sleep without any routing
  task automatic test_wake();
    wr(`PMPFGR_OFS_GPI_ROUTING, 4'hf, 32'h0);
    sleeping_i = 1'b1;
    gpi_event(5, 4'b0010);
    gpi_event(0, 4'b0010);
    group1_event_enable_i = 16'h0;
    gpi_event(5, 4'b0000);
    group1_event_enable_i = 16'hffff;
    sleeping_i = 1'b0;
  endtask

  // power restore policy and soft-off wake sources
  task automatic test_restore();
    wr(`PMPFGR_OFS_POLICY_STATUS, 4'h1, 32'h0);
    do_restore(1'b0, PWR_S0);
    wr(`PMPFGR_OFS_POLICY_STATUS, 4'h1, 32'h1);
    do_restore(1'b0, PWR_S5);
    do_wake(0, 4'b0000);
    do_wake(2, 4'b0010);
    chk_word({30'h0, restore_target_o}, {30'h0, PWR_S0}, "after wake");
    do_restore(1'b0, PWR_S5);
    do_wake(1, 4'b0010);
    do_restore(1'b1, PWR_S4);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    {arst_n_i, battery_well_reset_n_i, trickle_fail_i, cfg_wr_i, cfg_rd_i} = 5'h0;
    {reset_port_write_i, power_restored_i, was_in_s4_i, sleeping_i} = 4'h0;
    {power_button_event_i, preserved_wake_event_i, other_wake_event_i} = 3'h0;
    cfg_addr_i = 8'h0;
    cfg_be_i = 4'h0;
    cfg_wdata_i = 32'h0;
    gp_input_event_flag_i = 16'h0;
    group1_event_enable_i = 16'hffff;
    gpio_is_input_i = 16'hffff;
    repeat (3) @(posedge clock_i);
    #1;
    arst_n_i = 1'b1;
    battery_well_reset_n_i = 1'b1;
    repeat (4) @(posedge clock_i);
    test_status();
    test_trickle();
    test_route_regs();
    test_route_decode();
    test_wake();
    test_restore();
    report_and_stop();
  end
endmodule
